// ---- scl_loader.sv ----
// How it works
// (R1) Channels stay shut down until loaded
// (R2) Bit 6 selects slew limiting
// (R3) Bits 5..3 pick interface mode
// (R4) Bit 2 enables transmit termination
// (R5) Bit 1 enables receive termination
// (R6) Bit 0 low powers channel down
// (R7) Pins: latch 0, shift 2, address 5..3, data 6
// (R8) Addresses 0..3 select channels, others none
// (R9) Host clears levels, then sets directions 0x82
// (R10) Host leaves other pin registers default
// (R11) Host shifts seven bits, MSB first
// (R12) Host latches, then drives all lines low
// (R13) Shift data on rising shift clock
// (R14) Latch copies word to addressed channel only
// (R15) Slew change never disturbs traffic
// (R16) Request-to-send brackets transmission with delay
// (R17) Auto direction enable and delay control
// (R18) Full duplex: driver and receiver always on
// (R19) Half duplex inhibit blocks local echo
// (R20) Host picks half-duplex multi-point settings
// (R21) Single-ended mode ignores termination bits
`default_nettype none
module scl_loader #(
    parameter int NUM_CH = scl_pkg::NUM_CH,
    parameter int DELAY_W = scl_pkg::DELAY_W
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [scl_pkg::PIN_W-1:0] general_purpose_pin,
    input wire logic [NUM_CH-1:0] auto_dir_en,
    input wire logic [NUM_CH-1:0] enh_func_en,
    input wire logic [NUM_CH-1:0] delay_wr,
    input wire logic [DELAY_W-1:0] delay_wdata,
    input wire logic [NUM_CH-1:0] bit_tick,
    input wire logic [NUM_CH-1:0] tx_busy,
    input wire logic [NUM_CH-1:0] rx_inhibit_en,
    output logic [NUM_CH-1:0] slew_limit_select,
    output logic [NUM_CH-1:0] iface_code_bit_hi,
    output logic [NUM_CH-1:0] iface_code_bit_mid,
    output logic [NUM_CH-1:0] iface_code_bit_lo,
    output logic [NUM_CH-1:0] term_tx_en,
    output logic [NUM_CH-1:0] term_rx_en,
    output logic [NUM_CH-1:0] xcvr_powerdown_n,
    output logic [NUM_CH-1:0] driver_en,
    output logic [NUM_CH-1:0] receiver_en,
    output logic [NUM_CH-1:0] loopback_active,
    output logic [NUM_CH-1:0] mode_reserved
);
    localparam int SYNC_W = 6;
    localparam int S_LATCH = 0;
    localparam int S_SHIFT = 1;
    localparam int S_DATA = 2;
    localparam int S_ADDR = 3;

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    logic [SYNC_W-1:0] pins_rise;
    logic [scl_pkg::WORD_W-1:0] shift_r;
    logic [scl_pkg::WORD_W-1:0] word_r [NUM_CH];
    logic [NUM_CH-1:0] loaded_r;
    logic [DELAY_W-1:0] delay_r [NUM_CH];
    logic [NUM_CH-1:0] drive_raw;
    logic [scl_pkg::ADDR_W-1:0] addr_s;

    function automatic logic [2:0] mode_of(input logic [scl_pkg::WORD_W-1:0] w);
        mode_of = w[scl_pkg::BIT_MODE_HI:scl_pkg::BIT_MODE_LO];
    endfunction : mode_of

    function automatic logic is_single_ended(input logic [2:0] m);
        is_single_ended = (m == scl_pkg::MODE_SE) || (m == scl_pkg::MODE_SE_LOOP);
    endfunction : is_single_ended

    assign pins_raw = {
        general_purpose_pin[scl_pkg::PIN_ADDR_LO+2:scl_pkg::PIN_ADDR_LO], // R7
        general_purpose_pin[scl_pkg::PIN_DATA],
        general_purpose_pin[scl_pkg::PIN_SHIFT],
        general_purpose_pin[scl_pkg::PIN_LATCH]
    };

    // Bus pins come from the UART domain and are slow; two stages plus edge find
    scl_pin_sync #(
        .W(SYNC_W)
    ) u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .clk_en(clk_en),
        .async_in(pins_raw),
        .sync_out(pins_s),
        .rise_out(pins_rise)
    );

    assign addr_s = pins_s[S_ADDR+2:S_ADDR];

    always_ff @(posedge core_clk)
    begin
        if (srst)
            shift_r <= scl_pkg::WORD_RESET;
        else if (clk_en && pins_rise[S_SHIFT])
            shift_r <= {shift_r[scl_pkg::WORD_W-2:0], pins_s[S_DATA]}; // R13
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            loaded_r <= '0; // R1
            for (int i = 0; i < NUM_CH; i++)
                word_r[i] <= scl_pkg::WORD_RESET; // R6
        end
        else if (clk_en && pins_rise[S_LATCH])
        begin
            // Reserved addresses match no index and leave all words alone
            for (int i = 0; i < NUM_CH; i++)
                if (addr_s == scl_pkg::ADDR_W'(i)) // R8
                begin
                    word_r[i] <= shift_r; // R14
                    loaded_r[i] <= 1'b1;
                end
        end
    end

    // Delay field only accepts writes while enhanced functions are unlocked
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < NUM_CH; i++)
                delay_r[i] <= '0;
        end
        else if (clk_en)
        begin
            for (int i = 0; i < NUM_CH; i++)
                if (delay_wr[i] && enh_func_en[i])
                    delay_r[i] <= delay_wdata; // R17
        end
    end

    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
        scl_dir_ctrl #(
            .DELAY_W(DELAY_W)
        ) u_dir (
            .core_clk(core_clk),
            .srst(srst),
            .clk_en(clk_en),
            .auto_en(auto_dir_en[g]), // R17
            .delay_bits(delay_r[g]),
            .bit_tick(bit_tick[g]),
            .tx_busy(tx_busy[g]),
            .drive_en(drive_raw[g])
        );
    end

    // Outputs registered; slew bit is a plain level so it can change mid-frame
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            slew_limit_select <= '0;
            iface_code_bit_hi <= '0;
            iface_code_bit_mid <= '0;
            iface_code_bit_lo <= '0;
            term_tx_en <= '0;
            term_rx_en <= '0;
            xcvr_powerdown_n <= '0;
            driver_en <= '0;
            receiver_en <= '0;
            loopback_active <= '0;
            mode_reserved <= '0;
        end
        else if (clk_en)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                logic [2:0] m;
                logic up;
                m = mode_of(word_r[i]);
                up = loaded_r[i] && word_r[i][scl_pkg::BIT_PWR_N]; // R1 R6
                slew_limit_select[i] <= word_r[i][scl_pkg::BIT_SLEW]; // R2 R15
                iface_code_bit_hi[i] <= m[2]; // R3
                iface_code_bit_mid[i] <= m[1];
                iface_code_bit_lo[i] <= m[0];
                term_tx_en[i] <= !is_single_ended(m) && word_r[i][scl_pkg::BIT_TERM_TX]; // R4 R21
                term_rx_en[i] <= !is_single_ended(m) && word_r[i][scl_pkg::BIT_TERM_RX]; // R5 R21
                xcvr_powerdown_n[i] <= up;
                loopback_active[i] <= up && (m == scl_pkg::MODE_SE_LOOP
                    || m == scl_pkg::MODE_DIFF_LOOP
                    || (m == scl_pkg::MODE_DIFF_HD && !rx_inhibit_en[i])); // R19
                mode_reserved[i] <= !(m == scl_pkg::MODE_SE_LOOP || m == scl_pkg::MODE_SE
                    || m == scl_pkg::MODE_DIFF_HD || m == scl_pkg::MODE_DIFF_FD
                    || m == scl_pkg::MODE_DIFF_LOOP); // R3
                case (m)
                    scl_pkg::MODE_DIFF_FD:
                    begin
                        driver_en[i] <= up; // R18
                        receiver_en[i] <= up;
                    end
                    scl_pkg::MODE_DIFF_HD, scl_pkg::MODE_DIFF_LOOP:
                    begin
                        driver_en[i] <= up && drive_raw[i]; // R16
                        receiver_en[i] <= up && !(rx_inhibit_en[i] && drive_raw[i]); // R19
                    end
                    scl_pkg::MODE_SE, scl_pkg::MODE_SE_LOOP:
                    begin
                        driver_en[i] <= up; // R18
                        receiver_en[i] <= up;
                    end
                    default:
                    begin
                        driver_en[i] <= 1'b0;
                        receiver_en[i] <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule : scl_loader
`default_nettype wire

// ---- scl_pkg.sv ----
`default_nettype none
package scl_pkg;
    localparam int NUM_CH = 4;
    localparam int WORD_W = 7;
    localparam int ADDR_W = 3;
    localparam int PIN_W = 16;
    // Pin assignment of the configuration bus
    localparam int PIN_LATCH = 0;
    localparam int PIN_SHIFT = 2;
    localparam int PIN_ADDR_LO = 3;
    localparam int PIN_DATA = 6;
    // Control word fields
    localparam int BIT_SLEW = 6;
    localparam int BIT_MODE_HI = 5;
    localparam int BIT_MODE_LO = 3;
    localparam int BIT_TERM_TX = 2;
    localparam int BIT_TERM_RX = 1;
    localparam int BIT_PWR_N = 0;
    localparam logic [6:0] WORD_RESET = 7'h00;
    // Interface mode codes
    localparam logic [2:0] MODE_SE_LOOP = 3'h0;
    localparam logic [2:0] MODE_SE = 3'h2;
    localparam logic [2:0] MODE_DIFF_HD = 3'h1;
    localparam logic [2:0] MODE_DIFF_FD = 3'h3;
    localparam logic [2:0] MODE_DIFF_LOOP = 3'h7;
    // UART register map seen by the host
    localparam logic [11:0] OFS_PIN_LEVEL = 12'h090;
    localparam logic [11:0] OFS_PIN_DIR = 12'h093;
    localparam logic [7:0] PIN_LEVEL_RESET = 8'h00;
    localparam logic [7:0] PIN_DIR_RESET = 8'hff;
    localparam logic [7:0] PIN_DIR_BUS = 8'h82;
    localparam int LOAD_WRITES = 17;
    localparam int FEATURE_CONTROL_AUTO_DIR_BIT = 5;
    localparam int EFR_ENH_BIT = 4;
    localparam int MSR_DELAY_HI = 7;
    localparam int MSR_DELAY_LO = 4;
    localparam int DELAY_W = 4;
    // Slew-limited data rates in kbps, single-ended and differential
    localparam int SLEW_SE_KBPS = 250;
    localparam int SLEW_DIFF_KBPS = 500;
    typedef enum logic [1:0] {SCL_DIR_IDLE, SCL_DIR_SEND, SCL_DIR_HOLD} scl_dir_state_type;
endpackage : scl_pkg
`default_nettype wire

// ---- scl_pin_sync.sv ----
`default_nettype none
module scl_pin_sync #(
    parameter int W = 4
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out,
    output logic [W-1:0] rise_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] last_r;

    // Only sync_r reads meta_r
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            meta_r <= '0;
            sync_r <= '0;
            last_r <= '0;
        end
        else if (clk_en)
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign sync_out = sync_r;
    assign rise_out = sync_r & ~last_r & {W{clk_en}};
endmodule : scl_pin_sync
`default_nettype wire

// ---- scl_dir_ctrl.sv ----
`default_nettype none
module scl_dir_ctrl #(
    parameter int DELAY_W = 4
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic auto_en,
    input wire logic [DELAY_W-1:0] delay_bits,
    input wire logic bit_tick,
    input wire logic tx_busy,
    output logic drive_en
);
    scl_pkg::scl_dir_state_type state_r;
    logic [DELAY_W-1:0] cnt_r;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_r <= scl_pkg::SCL_DIR_IDLE;
            cnt_r <= '0;
        end
        else if (clk_en)
        begin
            case (state_r)
                scl_pkg::SCL_DIR_IDLE:
                    if (auto_en && tx_busy)
                        state_r <= scl_pkg::SCL_DIR_SEND;
                scl_pkg::SCL_DIR_SEND:
                    if (!tx_busy)
                    begin
                        state_r <= scl_pkg::SCL_DIR_HOLD;
                        cnt_r <= delay_bits;
                    end
                scl_pkg::SCL_DIR_HOLD:
                    if (tx_busy)
                        state_r <= scl_pkg::SCL_DIR_SEND;
                    else if (cnt_r == '0)
                        state_r <= scl_pkg::SCL_DIR_IDLE;
                    else if (bit_tick)
                        cnt_r <= cnt_r - 1'b1;
                default:
                    state_r <= scl_pkg::SCL_DIR_IDLE;
            endcase
        end
    end

    // Driver is up before the first start bit and holds past the last stop bit
    assign drive_en = auto_en && (tx_busy || state_r != scl_pkg::SCL_DIR_IDLE); // R16
endmodule : scl_dir_ctrl
`default_nettype wire

// ---- scl_loader_sva.sv ----
`default_nettype none
module scl_loader_chk #(
    parameter int NUM_CH = 4
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [scl_pkg::PIN_W-1:0] general_purpose_pin,
    input wire logic [NUM_CH-1:0] auto_dir_en,
    input wire logic [NUM_CH-1:0] tx_busy,
    input wire logic [NUM_CH-1:0] rx_inhibit_en,
    input wire logic [NUM_CH-1:0] slew_limit_select,
    input wire logic [NUM_CH-1:0] iface_code_bit_hi,
    input wire logic [NUM_CH-1:0] iface_code_bit_mid,
    input wire logic [NUM_CH-1:0] iface_code_bit_lo,
    input wire logic [NUM_CH-1:0] term_tx_en,
    input wire logic [NUM_CH-1:0] term_rx_en,
    input wire logic [NUM_CH-1:0] xcvr_powerdown_n,
    input wire logic [NUM_CH-1:0] driver_en,
    input wire logic [NUM_CH-1:0] receiver_en,
    input wire logic [NUM_CH-1:0] mode_reserved
);
    logic [NUM_CH-1:0] busy_r;
    wire logic [NUM_CH-1:0] pwr_lo = xcvr_powerdown_n & iface_code_bit_lo & ~iface_code_bit_hi;
    wire logic [NUM_CH-1:0] hd = pwr_lo & ~iface_code_bit_mid & auto_dir_en;
    wire logic [NUM_CH-1:0] fd = pwr_lo & iface_code_bit_mid;
    wire logic [NUM_CH-1:0] rise = tx_busy & ~busy_r & hd;
    always_ff @(posedge core_clk) busy_r <= tx_busy;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    chk_reset_quiet: assert property ($fell(srst) |-> (xcvr_powerdown_n | driver_en) == 0)
        else $error("outputs active after reset");
    chk_latch_cause: assert property ($changed({slew_limit_select, iface_code_bit_mid,
        xcvr_powerdown_n}) |-> $past(general_purpose_pin[0], 3))
        else $error("word changed without latch");
    chk_se_noterm: assert property (((term_tx_en | term_rx_en)
        & ~(iface_code_bit_hi | iface_code_bit_lo)) == 0)
        else $error("termination in single-ended mode");
    chk_reserved_flag: assert property (mode_reserved
        == (iface_code_bit_hi & ~(iface_code_bit_mid & iface_code_bit_lo)))
        else $error("reserved flag wrong");
    chk_reserved_off: assert property (((driver_en | receiver_en) & mode_reserved
        & $past(mode_reserved)) == 0)
        else $error("reserved mode enables transceiver");
    chk_pwr_driver: assert property ((driver_en & ~xcvr_powerdown_n
        & ~$past(xcvr_powerdown_n)) == 0)
        else $error("driver on while shut down");
    chk_fd_both: assert property (fd == $past(fd) && fd == $past(fd, 2)
        |-> (fd & ~(driver_en & receiver_en)) == 0)
        else $error("full duplex not both enabled");
    chk_hd_raise: assert property (rise != 0 |=> (driver_en & $past(rise)) == $past(rise))
        else $error("driver late for send");
    chk_hd_hold: assert property ((tx_busy & $past(tx_busy) & $past(tx_busy, 2) & hd
        & $past(hd) & ~driver_en) == 0)
        else $error("driver dropped during send");
    chk_rx_inhibit: assert property ((hd & rx_inhibit_en & driver_en & $past(driver_en)
        & receiver_en) == 0)
        else $error("receiver not inhibited");
endmodule : scl_loader_chk
bind scl_loader scl_loader_chk #(.NUM_CH(NUM_CH)) i_chk (.*);
`default_nettype wire

// ---- scl_host_model.sv ----
`default_nettype none
module scl_host_model (
    output var logic [scl_pkg::PIN_W-1:0] general_purpose_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] pin_level_ctrl = scl_pkg::PIN_LEVEL_RESET;
    logic [7:0] pin_direction_sel = scl_pkg::PIN_DIR_RESET;
    logic noise = 1'b0;
    always #5 noise = ~noise;
    // Bus lines sit on pull-downs while inputs; unused pins float
    always_comb general_purpose_pin = {{9{noise}}, pin_level_ctrl[6:2] & ~pin_direction_sel[6:2],
        noise, pin_level_ctrl[0] & ~pin_direction_sel[0]};
    task automatic write_reg(input logic [11:0] ofs, input logic [7:0] data);
        if (ofs == scl_pkg::OFS_PIN_LEVEL) pin_level_ctrl = data;
        else if (ofs == scl_pkg::OFS_PIN_DIR) pin_direction_sel = data;
        #32;
    endtask : write_reg
    task automatic load(input logic [2:0] adr, input logic [6:0] word);
        write_reg(scl_pkg::OFS_PIN_LEVEL, 8'h00);
        write_reg(scl_pkg::OFS_PIN_DIR, scl_pkg::PIN_DIR_BUS);
        write_reg(scl_pkg::OFS_PIN_LEVEL, {2'h0, adr, 3'h0});
        for (int b = 6; b >= 0; b--)
        begin
            write_reg(scl_pkg::OFS_PIN_LEVEL, {1'h0, word[b], adr, 3'h0});
            write_reg(scl_pkg::OFS_PIN_LEVEL, {1'h0, word[b], adr, 3'h4});
        end
        write_reg(scl_pkg::OFS_PIN_LEVEL, {2'h0, adr, 3'h1});
        write_reg(scl_pkg::OFS_PIN_LEVEL, 8'h00);
    endtask : load
endmodule : scl_host_model
`default_nettype wire

// ---- tb_top.sv ----
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int N = scl_pkg::NUM_CH;
    localparam logic [39:0] ALL = 40'hffffffff00;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    wire logic [15:0] general_purpose_pin;
    logic [N-1:0] auto_dir_en = '0, enh_func_en = '0, delay_wr = '0;
    logic [N-1:0] bit_tick = '0, tx_busy = '0, rx_inhibit_en = '0;
    logic [3:0] delay_wdata = 4'h0;
    logic [N-1:0] slew_limit_select, iface_code_bit_hi, iface_code_bit_mid, iface_code_bit_lo;
    logic [N-1:0] term_tx_en, term_rx_en, xcvr_powerdown_n, driver_en, receiver_en;
    logic [N-1:0] loopback_active, mode_reserved;
    wire logic [39:0] view = {slew_limit_select, iface_code_bit_hi, iface_code_bit_mid,
        iface_code_bit_lo, term_tx_en, term_rx_en, xcvr_powerdown_n, mode_reserved, driver_en,
        receiver_en};
    int n_errors = 0;
    int n_compared = 0;
    logic [6:0] word_r [N];
    logic [79:0] exp_q [$];
    event ready_ev;
    always #2 core_clk = ~core_clk;
    scl_loader i_scl_loader (.*);
    scl_host_model i_scl_host_model (.*);
    function automatic logic [39:0] expv();
        logic [39:0] e;
        logic [7:0] v;
        logic se;
        e = '0;
        for (int c = 0; c < N; c++)
        begin
            se = word_r[c][5:3] == scl_pkg::MODE_SE || word_r[c][5:3] == scl_pkg::MODE_SE_LOOP;
            v = {word_r[c][6:3], word_r[c][2:1] & {2{~se}}, word_r[c][0],
                word_r[c][5] & ~(word_r[c][4] & word_r[c][3])};
            for (int k = 0; k < 8; k++) e[8 + k * N + c] = v[k];
        end
        return e;
    endfunction : expv
    // Unloaded words are all zero, so bit 0 alone tells whether a channel is up
    function automatic logic [N-1:0] expl();
        logic [N-1:0] l;
        logic [2:0] m;
        l = '0;
        for (int c = 0; c < N; c++)
        begin
            m = word_r[c][5:3];
            l[c] = word_r[c][0] && (m == scl_pkg::MODE_SE_LOOP || m == scl_pkg::MODE_DIFF_LOOP
                || (m == scl_pkg::MODE_DIFF_HD && !rx_inhibit_en[c]));
        end
        return l;
    endfunction : expl
    task automatic check(input string nm, input logic [39:0] e, input logic [39:0] s);
        n_compared++;
        if (s !== e)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic complete_run();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run
    task automatic note(input logic [39:0] m, input logic [39:0] e);
        exp_q.push_back({m, e});
        ->ready_ev;
        #4;
    endtask : note
    always @(ready_ev)
    begin
        logic [39:0] m;
        logic [39:0] e;
        {m, e} = exp_q.pop_front();
        check("outputs", e & m, view & m);
    end
    task automatic load(input logic [2:0] a, input logic [6:0] w);
        i_scl_host_model.load(a, w);
        if (a < N) word_r[a] = w;
        note(ALL, expv());
        check("loopback", 40'(expl()), 40'(loopback_active));
    endtask : load
    task automatic tick_wait(input int n);
        bit_tick[0] = n[0];
        delay_wr[0] = n[1];
        @(posedge core_clk);
        #1 bit_tick[0] = 1'b0;
        delay_wr[0] = 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
    endtask : tick_wait
    initial
    begin
        #40000;
        n_errors++;
        complete_run();
    end
    initial
    begin
        logic [6:0] w;
        logic [2:0] modes [6];
        modes = '{scl_pkg::MODE_SE_LOOP, scl_pkg::MODE_SE, scl_pkg::MODE_DIFF_HD,
            scl_pkg::MODE_DIFF_FD, scl_pkg::MODE_DIFF_LOOP, 3'h5};
        void'($urandom(32'hb34b));
        for (int c = 0; c < N; c++) word_r[c] = 7'h00;
        repeat (3) @(posedge core_clk);
        #1 srst = 1'b0;
        note(ALL, expv());
        for (int i = 0; i < 12; i++)
        begin
            w = 7'($urandom());
            if (i < 6) w[5:3] = modes[i];
            load(i < 10 ? 3'(i % N) : 3'(4 + $urandom_range(3)), w);
        end
        load(3'h1, 7'h19);
        load(3'h2, 7'h21);
        note(40'h66, 40'h22);
        rx_inhibit_en = 4'h1;
        auto_dir_en = 4'h1;
        enh_func_en = 4'h1;
        load(3'h0, 7'h0d);
        delay_wdata = 4'h2;
        tick_wait(2);
        enh_func_en = 4'h0;
        delay_wdata = 4'h9;
        tick_wait(2);
        tx_busy[0] = 1'b1;
        tick_wait(0);
        note(40'h11, 40'h10);
        load(3'h0, 7'h4d);
        note(40'h11, 40'h10);
        tx_busy[0] = 1'b0;
        tick_wait(1);
        note(40'h10, 40'h10);
        // The tick that falls with the end of the send is not counted
        tick_wait(1);
        note(40'h10, 40'h10);
        tick_wait(1);
        note(40'h10, 40'h00);
        srst = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 srst = 1'b0;
        for (int c = 0; c < N; c++) word_r[c] = 7'h00;
        note(ALL, expv());
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
